// file: balu_alu.sv
`timescale 1ns/10ps
module balu_alu
  import balu_pkg::*;
#(
  parameter int unsigned WIDTH = BALU_WIDTH
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Request from the controller
  input  wire logic             op_valid,
  input  wire balu_op_type      op_sel,
  input  wire logic [WIDTH-1:0] dst_byte,
  input  wire logic [WIDTH-1:0] src_byte,
  input  wire logic             carry_bit_in,
  // Answer to the controller
  output logic                  done_q,
  output logic      [WIDTH-1:0] result_q,
  output logic                  result_we_q,
  output logic                  zero_bit_q,
  output logic                  half_carry_bit_q,
  output logic                  carry_bit_q
);

  // Datapath wires
  logic [WIDTH-1:0] add_sum;
  logic             add_cout;
  logic             add_c4;
  logic             add_cin;
  logic             add_sub;
  logic [WIDTH-1:0] log_res;
  balu_logic_type   log_func;

  // Next values
  logic             done_d;
  logic [WIDTH-1:0] result_d;
  logic             result_we_d;
  logic             zero_bit_d;
  logic             half_carry_bit_d;
  logic             carry_bit_d;

  // Adder configuration per operation
  always_comb begin
    add_sub = 1'b0;
    add_cin = 1'b0;
    case (op_sel)
      BALU_SUM_OP: begin
        add_cin = 1'b0;
      end
      BALU_SUM_WITH_CARRY_OP: begin
        add_cin = carry_bit_in;
      end
      BALU_DIFFERENCE_OP,
      BALU_COMPARE_OP: begin
        add_sub = 1'b1;
        add_cin = 1'b1;
      end
      BALU_DIFFERENCE_WITH_BORROW_OP: begin
        add_sub = 1'b1;
        add_cin = ~carry_bit_in;
      end
      default: begin
        add_sub = 1'b0;
        add_cin = 1'b0;
      end
    endcase
  end

  // Bitwise function per operation
  always_comb begin
    case (op_sel)
      BALU_CONJ_OP: log_func = BALU_LOGIC_AND;
      BALU_DISJ_OP: log_func = BALU_LOGIC_OR;
      BALU_EXCL_OP: log_func = BALU_LOGIC_XOR;
      default:      log_func = BALU_LOGIC_XOR;
    endcase
  end

  // Shared add and subtract path
  balu_adder #(
    .WIDTH         (WIDTH)
  ) u_adder (
    .a_in          (dst_byte),
    .b_in          (src_byte),
    .cin           (add_cin),
    .sub_en        (add_sub),
    .sum_out       (add_sum),
    .carry_out     (add_cout),
    .nib_carry_out (add_c4)
  );

  // Bitwise path
  balu_logic #(
    .WIDTH   (WIDTH)
  ) u_logic (
    .a_in    (dst_byte),
    .b_in    (src_byte),
    .func    (log_func),
    .res_out (log_res)
  );

  // Result, flags and write enable for the next cycle
  always_comb begin
    done_d           = op_valid;
    result_d         = result_q;
    result_we_d      = 1'b0;
    zero_bit_d       = zero_bit_q;
    half_carry_bit_d = half_carry_bit_q;
    carry_bit_d      = carry_bit_q;
    if (op_valid) begin
      case (op_sel)
        BALU_SUM_OP,
        BALU_SUM_WITH_CARRY_OP: begin
          result_d         = add_sum;
          result_we_d      = 1'b1;
          zero_bit_d       = (add_sum == BALU_ZERO_BYTE);
          carry_bit_d      = add_cout;
          half_carry_bit_d = add_c4;
        end
        BALU_DIFFERENCE_OP,
        BALU_DIFFERENCE_WITH_BORROW_OP,
        BALU_COMPARE_OP: begin
          result_d         = add_sum;
          result_we_d      = (op_sel != BALU_COMPARE_OP);
          zero_bit_d       = (add_sum == BALU_ZERO_BYTE);
          carry_bit_d      = ~add_cout;
          half_carry_bit_d = ~add_c4;
        end
        BALU_CONJ_OP,
        BALU_DISJ_OP,
        BALU_EXCL_OP: begin
          result_d         = log_res;
          result_we_d      = 1'b1;
          zero_bit_d       = (log_res == BALU_ZERO_BYTE);
        end
        default: begin
          result_d    = result_q;
          result_we_d = 1'b0;
        end
      endcase
    end
  end

  // Output and flag registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      done_q           <= 1'b0;
      result_q         <= BALU_RESULT_RST;
      result_we_q      <= 1'b0;
      zero_bit_q       <= BALU_FLAG_RST;
      half_carry_bit_q <= BALU_FLAG_RST;
      carry_bit_q      <= BALU_FLAG_RST;
    end else begin
      done_q           <= done_d;
      result_q         <= result_d;
      result_we_q      <= result_we_d;
      zero_bit_q       <= zero_bit_d;
      half_carry_bit_q <= half_carry_bit_d;
      carry_bit_q      <= carry_bit_d;
    end
  end

  // Sum result and carry-out against a wide reference
  a_sum_result: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_SUM_OP |=>
      {carry_bit_q, result_q} == {1'b0, $past(dst_byte)} + {1'b0,
        $past(src_byte)} && result_we_q && done_q)
    else $error("sum result or carry wrong");

  // Zero flag after additions
  a_sum_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && (op_sel == BALU_SUM_OP || op_sel == BALU_SUM_WITH_CARRY_OP)
      |=> zero_bit_q == (result_q == BALU_ZERO_BYTE))
    else $error("zero flag wrong after addition");

  // Carry out of bit 7 on plain sums
  a_sum_carry: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_SUM_OP && dst_byte[BALU_MSB]
      && src_byte[BALU_MSB] |=> carry_bit_q)
    else $error("carry from bit 7 missed");

  // Half carry from the low nibble
  a_sum_half: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_SUM_OP |=>
      half_carry_bit_q == (({1'b0, $past(dst_byte[BALU_NIB_LO:0])}
        + {1'b0, $past(src_byte[BALU_NIB_LO:0])}) > 5'h0F))
    else $error("half carry wrong after addition");

  // Incoming carry enters at bit 0
  a_sum_with_carry_op_result: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_SUM_WITH_CARRY_OP |=>
      {carry_bit_q, result_q} == {1'b0, $past(dst_byte)}
        + {1'b0, $past(src_byte)} + {8'h00, $past(carry_bit_in)})
    else $error("sum with carry wrong");

  // Difference and borrow
  a_diff_result: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_DIFFERENCE_OP |=>
      result_q == $past(dst_byte) - $past(src_byte) && result_we_q
      && carry_bit_q == ($past(dst_byte) < $past(src_byte)))
    else $error("difference or borrow wrong");

  // Zero flag after plain difference and compare
  a_diff_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && (op_sel == BALU_DIFFERENCE_OP || op_sel == BALU_COMPARE_OP)
      |=> zero_bit_q == ($past(dst_byte) == $past(src_byte)))
    else $error("zero flag wrong after subtraction");

  // Borrow at bit 7 on subtraction with borrow
  a_difference_with_borrow_op_borrow: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_DIFFERENCE_WITH_BORROW_OP |=>
      carry_bit_q == ({1'b0, $past(dst_byte)} < {1'b0, $past(src_byte)}
        + {8'h00, $past(carry_bit_in)}))
    else $error("borrow at bit 7 wrong");

  // Half borrow from bit 4 to bit 3
  a_diff_half: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_COMPARE_OP |=>
      half_carry_bit_q == ($past(dst_byte[BALU_NIB_LO:0])
        < $past(src_byte[BALU_NIB_LO:0])))
    else $error("half borrow wrong");

  // Incoming carry subtracted at bit 0
  a_difference_with_borrow_op_result: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_DIFFERENCE_WITH_BORROW_OP |=>
      result_q == $past(dst_byte) - $past(src_byte)
        - {7'h00, $past(carry_bit_in)})
    else $error("difference with borrow wrong");

  // Compare never writes back
  a_cmp_nowrite: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_COMPARE_OP |=> done_q && !result_we_q)
    else $error("compare asked for a write");

  // Conjunction result
  a_and_result: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_CONJ_OP |=>
      result_q == ($past(dst_byte) & $past(src_byte)) && result_we_q)
    else $error("conjunction wrong");

  // Disjunction result
  a_or_result: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_DISJ_OP |=>
      result_q == ($past(dst_byte) | $past(src_byte)) && result_we_q)
    else $error("disjunction wrong");

  // Exclusive-or result
  a_xor_result: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_EXCL_OP |=>
      result_q == ($past(dst_byte) ^ $past(src_byte)) && result_we_q)
    else $error("exclusive-or wrong");

  // All-ones source inverts the destination
  a_xor_invert: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_EXCL_OP && src_byte == BALU_ONES_BYTE
      |=> result_q == ~$past(dst_byte))
    else $error("inversion by exclusive-or failed");

  // Zero flag after bitwise ops
  a_logic_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && (op_sel == BALU_CONJ_OP || op_sel == BALU_DISJ_OP
      || op_sel == BALU_EXCL_OP) |=>
      zero_bit_q == (result_q == BALU_ZERO_BYTE))
    else $error("zero flag wrong after bitwise op");

  // Bitwise ops hold carry and half carry
  a_logic_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && (op_sel == BALU_CONJ_OP || op_sel == BALU_DISJ_OP
      || op_sel == BALU_EXCL_OP) |=> $stable(carry_bit_q)
      && $stable(half_carry_bit_q))
    else $error("bitwise op changed carry flags");

  // Idle cycles hold result, zero and carry and give no answer
  a_idle_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !op_valid |=> !done_q && !result_we_q && $stable(result_q)
      && $stable(zero_bit_q) && $stable(carry_bit_q))
    else $error("output moved without a request");

  // Half borrow on plain difference
  a_sub_half: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_DIFFERENCE_OP |=>
      half_carry_bit_q == ($past(dst_byte[BALU_NIB_LO:0])
        < $past(src_byte[BALU_NIB_LO:0])))
    else $error("half borrow wrong after difference");

  // Half borrow with the incoming carry taken at bit 0
  a_difference_with_borrow_op_half: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_DIFFERENCE_WITH_BORROW_OP |=>
      half_carry_bit_q == ({1'b0, $past(dst_byte[BALU_NIB_LO:0])}
        < {1'b0, $past(src_byte[BALU_NIB_LO:0])}
        + {4'h0, $past(carry_bit_in)}))
    else $error("half borrow wrong after difference with borrow");

  // Zero flag after difference with borrow
  a_difference_with_borrow_op_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_DIFFERENCE_WITH_BORROW_OP |=>
      zero_bit_q == ($past(dst_byte) - $past(src_byte)
        - {7'h00, $past(carry_bit_in)} == BALU_ZERO_BYTE))
    else $error("zero flag wrong after difference with borrow");

  // Half carry with the incoming carry added at bit 0
  a_sum_with_carry_op_half: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_sel == BALU_SUM_WITH_CARRY_OP |=>
      half_carry_bit_q == (({1'b0, $past(dst_byte[BALU_NIB_LO:0])}
        + {1'b0, $past(src_byte[BALU_NIB_LO:0])}
        + {4'h0, $past(carry_bit_in)}) > 5'h0F))
    else $error("half carry wrong after sum with carry");

  // Every taken request answers next cycle; compare never writes
  a_done_pulse: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op_valid |=> done_q
      && result_we_q == ($past(op_sel) != BALU_COMPARE_OP))
    else $error("answer strobe or write enable wrong");

endmodule : balu_alu

// file: balu_pkg.sv
package balu_pkg;

  // Operand and result width
  localparam int unsigned BALU_WIDTH = 8;

  // Bit positions used by the carry logic
  localparam int unsigned BALU_MSB       = 7;
  localparam int unsigned BALU_NIB_HI    = 4;
  localparam int unsigned BALU_NIB_LO    = 3;

  // Special operand values
  localparam logic [7:0] BALU_ZERO_BYTE  = 8'h00;
  localparam logic [7:0] BALU_ONES_BYTE  = 8'hFF;

  // Reset values of the outputs and held flags
  localparam logic [7:0] BALU_RESULT_RST = 8'h00;
  localparam logic       BALU_FLAG_RST   = 1'b0;

  // Operation select
  typedef enum logic [2:0] {
    BALU_SUM_OP,
    BALU_SUM_WITH_CARRY_OP,
    BALU_DIFFERENCE_OP,
    BALU_DIFFERENCE_WITH_BORROW_OP,
    BALU_COMPARE_OP,
    BALU_CONJ_OP,
    BALU_DISJ_OP,
    BALU_EXCL_OP
  } balu_op_type;

  // Bitwise function select for the logic unit
  typedef enum logic [1:0] {
    BALU_LOGIC_AND,
    BALU_LOGIC_OR,
    BALU_LOGIC_XOR
  } balu_logic_type;

endpackage : balu_pkg

// file: balu_adder.sv
`timescale 1ns/10ps
module balu_adder
  import balu_pkg::*;
#(
  parameter int unsigned WIDTH = BALU_WIDTH
) (
  // Operands
  input  wire logic [WIDTH-1:0] a_in,
  input  wire logic [WIDTH-1:0] b_in,
  input  wire logic             cin,
  input  wire logic             sub_en,
  // Results
  output logic      [WIDTH-1:0] sum_out,
  output logic                  carry_out,
  output logic                  nib_carry_out
);

  logic [WIDTH:0]   carry_chain;
  logic [WIDTH-1:0] b_eff;

  // Subtraction adds the inverted source
  assign b_eff          = sub_en ? ~b_in : b_in;
  assign carry_chain[0] = cin;

  // Ripple chain, one full adder per bit
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      assign sum_out[gi]       = a_in[gi] ^ b_eff[gi] ^ carry_chain[gi];
      assign carry_chain[gi+1] = (a_in[gi] & b_eff[gi]) |
                                 (carry_chain[gi] & (a_in[gi] ^ b_eff[gi]));
    end
  endgenerate

  // Carry out of the top bit and out of the low nibble
  assign carry_out     = carry_chain[WIDTH];
  assign nib_carry_out = carry_chain[BALU_NIB_HI];

endmodule : balu_adder

// file: balu_logic.sv
`timescale 1ns/10ps
module balu_logic
  import balu_pkg::*;
#(
  parameter int unsigned WIDTH = BALU_WIDTH
) (
  // Operands and function
  input  wire logic [WIDTH-1:0] a_in,
  input  wire logic [WIDTH-1:0] b_in,
  input  wire balu_logic_type   func,
  // Result
  output logic      [WIDTH-1:0] res_out
);

  // One gate per bit, function chosen by select
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_comb begin
        case (func)
          BALU_LOGIC_AND: res_out[gi] = a_in[gi] & b_in[gi];
          BALU_LOGIC_OR:  res_out[gi] = a_in[gi] | b_in[gi];
          BALU_LOGIC_XOR: res_out[gi] = a_in[gi] ^ b_in[gi];
          default:        res_out[gi] = a_in[gi] ^ b_in[gi];
        endcase
      end
    end
  endgenerate

endmodule : balu_logic

// file: balu_ctrl_model.sv
`timescale 1ns/10ps
module balu_ctrl_model
  import balu_pkg::*;
(
  // Clock and carry fed back from the block
  input  wire logic  clk_sys,
  input  wire logic  carry_bit_q,
  // Request to the block
  output logic       op_valid,
  output balu_op_type op_sel,
  output logic [7:0] dst_byte,
  output logic [7:0] src_byte,
  output logic       carry_bit_in
);

  // Quiet request lines at time zero
  initial begin
    op_valid     = 1'b0;
    op_sel       = BALU_SUM_OP;
    dst_byte     = 8'h00;
    src_byte     = 8'h00;
    carry_bit_in = 1'b0;
  end

  // Any operand form arrives here as a byte pair in one cycle
  task automatic send(input balu_op_type op, input logic [7:0] d,
                      input logic [7:0] s, input logic ci,
                      input logic fb);
    logic cv;
    cv = fb ? carry_bit_q : ci;  // Chained ops feed back the held carry
    @(posedge clk_sys);
    op_valid     <= 1'b1;
    op_sel       <= op;
    dst_byte     <= d;
    src_byte     <= s;
    carry_bit_in <= cv;
  endtask : send

  // Idle cycle; stale operands are scrambled so nothing relies on them
  task automatic idle;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    dst_byte <= ~dst_byte;
    src_byte <= ~src_byte;
  endtask : idle

endmodule : balu_ctrl_model

// file: tb.sv
`timescale 1ns/10ps
module tb
  import balu_pkg::*;
;
  typedef struct packed {
    balu_op_type op;
    logic [7:0]  d;
    logic [7:0]  s;
    logic        ci;
    logic [7:0]  r;
    logic [3:0]  f;  // Zero, half, carry, write enable
  } balu_row_type;

  logic        clk_sys;
  logic        rst_n;
  logic        op_valid;
  balu_op_type op_sel;
  logic [7:0]  dst_byte;
  logic [7:0]  src_byte;
  logic        carry_bit_in;
  logic        done_q;
  logic [7:0]  result_q;
  logic        result_we_q;
  logic        zero_bit_q;
  logic        half_carry_bit_q;
  logic        carry_bit_q;
  int          miscompares;
  int          checks_done;

  // Back-to-back cases; carry and half carry of bitwise rows hold the prior row's values
  balu_row_type rows [21] = '{
    '{BALU_SUM_OP,  8'h0F, 8'h01, 1'h0, 8'h10, 4'h5},
    '{BALU_SUM_OP,  8'hF0, 8'h10, 1'h0, 8'h00, 4'hB},
    '{BALU_SUM_WITH_CARRY_OP, 8'h0F, 8'h00, 1'h1, 8'h10, 4'h5},
    '{BALU_SUM_WITH_CARRY_OP, 8'hFF, 8'h00, 1'h1, 8'h00, 4'hF},
    '{BALU_SUM_WITH_CARRY_OP, 8'h7F, 8'h80, 1'h0, 8'hFF, 4'h1},
    '{BALU_DIFFERENCE_OP, 8'h10, 8'h01, 1'h1, 8'h0F, 4'h5},
    '{BALU_DIFFERENCE_OP, 8'h00, 8'h01, 1'h0, 8'hFF, 4'h7},
    '{BALU_DIFFERENCE_OP, 8'h55, 8'h55, 1'h0, 8'h00, 4'h9},
    '{BALU_DIFFERENCE_WITH_BORROW_OP, 8'h10, 8'h0F, 1'h1, 8'h00, 4'hD},
    '{BALU_DIFFERENCE_WITH_BORROW_OP, 8'h00, 8'h00, 1'h1, 8'hFF, 4'h7},
    '{BALU_COMPARE_OP, 8'h38, 8'h38, 1'h0, 8'h00, 4'h8},
    '{BALU_COMPARE_OP, 8'h01, 8'h02, 1'h0, 8'hFF, 4'h6},
    '{BALU_CONJ_OP, 8'hF0, 8'h3C, 1'h0, 8'h30, 4'h7},
    '{BALU_CONJ_OP, 8'hF0, 8'h0F, 1'h0, 8'h00, 4'hF},
    '{BALU_DISJ_OP, 8'hA0, 8'h05, 1'h0, 8'hA5, 4'h7},
    '{BALU_EXCL_OP, 8'h5A, 8'hFF, 1'h0, 8'hA5, 4'h7},
    '{BALU_EXCL_OP, 8'h3C, 8'h3C, 1'h0, 8'h00, 4'hF},
    '{BALU_SUM_OP,  8'h08, 8'h08, 1'h1, 8'h10, 4'h5},
    '{BALU_EXCL_OP, 8'h00, 8'hFF, 1'h0, 8'hFF, 4'h5},
    '{BALU_SUM_OP,  8'h80, 8'h80, 1'h0, 8'h00, 4'hB},
    '{BALU_DISJ_OP, 8'h00, 8'h01, 1'h0, 8'h01, 4'h3}
  };

  balu_alu dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid),
    .op_sel(op_sel), .dst_byte(dst_byte), .src_byte(src_byte),
    .carry_bit_in(carry_bit_in), .done_q(done_q), .result_q(result_q),
    .result_we_q(result_we_q), .zero_bit_q(zero_bit_q),
    .half_carry_bit_q(half_carry_bit_q), .carry_bit_q(carry_bit_q)
  );

  balu_ctrl_model model_u (
    .clk_sys(clk_sys), .carry_bit_q(carry_bit_q), .op_valid(op_valid),
    .op_sel(op_sel), .dst_byte(dst_byte), .src_byte(src_byte),
    .carry_bit_in(carry_bit_in)
  );

  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic cmp_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_byte

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_bit

  // Whole answer of one taken request
  task automatic check_row(input logic [7:0] r, input logic [3:0] f);
    cmp_byte("result", r, result_q);
    cmp_bit("zero", f[3], zero_bit_q);
    cmp_bit("half", f[2], half_carry_bit_q);
    cmp_bit("carry", f[1], carry_bit_q);
    cmp_bit("write", f[0], result_we_q);
    cmp_bit("done", 1'b1, done_q);
  endtask : check_row

  // Two-byte operation, high byte chained on the fed-back carry
  task automatic chain(input balu_op_type lo, input balu_op_type hi,
                       input logic [15:0] a, input logic [15:0] b,
                       input logic [15:0] e);
    model_u.send(lo, a[7:0], b[7:0], 1'b0, 1'b0);
    model_u.idle();
    #1;
    cmp_byte("low", e[7:0], result_q);
    model_u.send(hi, a[15:8], b[15:8], 1'b0, 1'b1);
    model_u.idle();
    #1;
    cmp_byte("high", e[15:8], result_q);
  endtask : chain

  // Watchdog
  initial begin
    repeat (1000) @(posedge clk_sys);
    miscompares++;
    finish_test();
  end

  // Main sequence
  initial begin
    miscompares = 0;
    checks_done = 0;
    rst_n = 1'b0;
    repeat (16) @(posedge clk_sys);
    #1;
    check_row_zero();
    @(posedge clk_sys);
    rst_n <= 1'b1;
    model_u.idle();
    #1;
    check_row_zero();
    for (int i = 0; i <= 21; i++) begin
      if (i < 21) begin
        model_u.send(rows[i].op, rows[i].d, rows[i].s, rows[i].ci, 1'b0);
      end else begin
        model_u.idle();
      end
      #1;
      if (i > 0) begin
        check_row(rows[i-1].r, rows[i-1].f);
      end
    end
    // Idle cycle: strobes drop, values hold
    model_u.idle();
    #1;
    cmp_bit("done", 1'b0, done_q);
    cmp_bit("write", 1'b0, result_we_q);
    cmp_byte("result", 8'h01, result_q);
    chain(BALU_SUM_OP, BALU_SUM_WITH_CARRY_OP, 16'h12FF, 16'h0101,
          16'h1400);
    chain(BALU_DIFFERENCE_OP, BALU_DIFFERENCE_WITH_BORROW_OP, 16'h1200,
          16'h0001, 16'h11FF);
    // Reset in mid-run wins over a request; strobe drops before release
    model_u.send(BALU_SUM_OP, 8'hFF, 8'hFF, 1'b1, 1'b0);
    rst_n <= 1'b0;
    model_u.idle();
    #1;
    check_row_zero();
    model_u.idle();
    rst_n <= 1'b1;
    model_u.idle();
    #1;
    check_row_zero();
    // First request after release is taken normally
    model_u.send(BALU_SUM_OP, 8'h0F, 8'h01, 1'b0, 1'b0);
    model_u.idle();
    #1;
    check_row(8'h10, 4'h5);
    finish_test();
  end

  // All answer outputs at their reset values
  task automatic check_row_zero;
    cmp_byte("rst result", BALU_RESULT_RST, result_q);
    cmp_bit("rst done", BALU_FLAG_RST, done_q);
    cmp_bit("rst write", BALU_FLAG_RST, result_we_q);
    cmp_bit("rst zero", BALU_FLAG_RST, zero_bit_q);
    cmp_bit("rst half", BALU_FLAG_RST, half_carry_bit_q);
    cmp_bit("rst carry", BALU_FLAG_RST, carry_bit_q);
  endtask : check_row_zero

endmodule : tb
